// [logic/ahb_access_port_control.sv]
// ahb access port control word with ahb-lite register slave
//
// The implementer's own choices: register access over AHB-Lite and the address map.
`include "ahb_port_control_defines.svh"

module ahb_access_port_control #(
  parameter bit         HAS_NONSEC     = 1'b1,
  parameter bit         HAS_REQ_EMU    = 1'b1,
  parameter bit         ENHANCED_PROT  = 1'b0,
  parameter bit         HAS_SECURE_DBG = 1'b1,
  parameter bit         SDEV_TRACKS    = 1'b1,
  parameter bit         HAS_PACKED_INC = 1'b1,
  // requester identities are arbitrary values
  parameter logic [3:0] OWN_REQ_ID     = 4'h1,
  parameter logic [3:0] EMU_REQ_ID     = 4'h2
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // ahb-lite register slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // status pins from outside the clock domain
  input  wire logic        secure_debug_auth_i,
  input  wire logic        transfer_in_progress_i,
  input  wire logic        port_device_enabled_i,
  // outgoing requester sideband
  output logic             hnonsec_o,
  output logic [3:0]       hmaster_o,
  output logic [6:0]       hprot_o,
  output logic [2:0]       xfer_hsize_o,
  output logic [1:0]       address_increment_mode_o,
  output logic             debug_software_access_enable_o,
  output logic             stop_on_error_o,
  output logic             error_no_passthrough_o
);

  localparam logic [31:0] ONE = 32'h1;

  // fields software may change; build options decide the rest
  localparam logic [31:0] WMASK_BASE =
    (ONE << `BIT_SW_ENABLE) |
    (ONE << `BIT_STOP_ON_ERR) |
    (ONE << `BIT_ERR_NO_PASS) |
    (32'hf << `BIT_PROT_LO) |
    (32'h3 << `BIT_INC_LO) |
    (32'h7 << `BIT_SIZE_LO);

  localparam logic [31:0] WMASK_NONSEC =
    HAS_NONSEC ? (ONE << `BIT_NONSEC) : 32'h0; // RULE_02

  localparam logic [31:0] WMASK_REQ =
    HAS_REQ_EMU ? (ONE << `BIT_REQ_SELECT) : 32'h0; // RULE_06 RULE_07

  localparam logic [31:0] WMASK_ENH = ENHANCED_PROT ?
    ((ONE << `BIT_PROT_ENH4) | (ONE << `BIT_PROT_ENH6)) : 32'h0;

  // status bit and reserved bits never enter the store
  localparam logic [31:0] WMASK =
    WMASK_BASE | WMASK_NONSEC | WMASK_REQ | WMASK_ENH; // RULE_11 RULE_17 RULE_16

  localparam logic [31:0] WORD_RESET =
    (HAS_NONSEC ? (ONE << `BIT_NONSEC) : 32'h0) | // RULE_03
    (HAS_REQ_EMU ? (ONE << `BIT_REQ_SELECT) : 32'h0) |
    ({28'h0, `PROT_RESET} << `BIT_PROT_LO) |
    ({30'h0, `INC_RESET} << `BIT_INC_LO) |
    ({29'h0, `SIZE_RESET} << `BIT_SIZE_LO);

  // pin synchronisers
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;

  // bus data-phase state
  logic                   wr_pend_reg;
  logic                   wr_pend_next;
  logic                   rd_hit;

  // stored control word
  ahb_port_control_pkg::word_t word_reg;
  ahb_port_control_pkg::word_t word_next;
  ahb_port_control_pkg::word_t read_value;
  logic [31:0]                 hrdata_reg;
  logic [31:0]                 hrdata_next;

  logic       sdev_status;
  logic [2:0] wr_size;
  logic [1:0] wr_inc;
  logic       size_ok;
  logic       inc_ok;

  // two flops per pin; only the second is read
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end else begin
      pin_meta_reg <= {secure_debug_auth_i, transfer_in_progress_i,
                       port_device_enabled_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // address phase decode: access of any size to the one mapped offset
  always_comb begin
    wr_pend_next = 1'b0;
    rd_hit       = 1'b0;
    if (hsel_i && hready_i && htrans_i[1]) begin
      if (haddr_i[`BUS_ADDR_W-1:0] == `CTRL_WORD_OFFSET) begin
        wr_pend_next = hwrite_i;
        rd_hit       = !hwrite_i;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_reg <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
    end
  end

  // zero wait states, always okay
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  always_comb begin
    case ({HAS_SECURE_DBG, SDEV_TRACKS})
      2'b11:   sdev_status = pin_sync_reg[2]; // RULE_13
      2'b10:   sdev_status = 1'b1;
      default: sdev_status = 1'b0; // RULE_12
    endcase
  end

  // illegal size or increment writes leave the field unchanged
  assign wr_size = hwdata_i[`BIT_SIZE_HI:`BIT_SIZE_LO];
  assign wr_inc  = hwdata_i[`BIT_INC_HI:`BIT_INC_LO];
  assign size_ok = (wr_size == ahb_port_control_pkg::size_byte) ||
                   (wr_size == ahb_port_control_pkg::size_half) ||
                   (wr_size == ahb_port_control_pkg::size_word); // RULE_14

  always_comb begin
    case (ahb_port_control_pkg::addr_inc_e'(wr_inc))
      ahb_port_control_pkg::inc_off:    inc_ok = 1'b1;
      ahb_port_control_pkg::inc_single: inc_ok = 1'b1;
      ahb_port_control_pkg::inc_packed: inc_ok = HAS_PACKED_INC; // RULE_15
      default:                          inc_ok = 1'b0;
    endcase
  end

  always_comb begin
    word_next = word_reg;
    if (wr_pend_reg) begin
      word_next = (word_reg & ~WMASK) | (hwdata_i & WMASK); // RULE_17
      if (!size_ok) begin
        word_next[`BIT_SIZE_HI:`BIT_SIZE_LO] =
          word_reg[`BIT_SIZE_HI:`BIT_SIZE_LO];
      end
      if (!inc_ok) begin
        word_next[`BIT_INC_HI:`BIT_INC_LO] =
          word_reg[`BIT_INC_HI:`BIT_INC_LO];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_reg <= WORD_RESET;
    end else begin
      word_reg <= word_next;
    end
  end

  // status bits are merged only on read, never stored
  always_comb begin
    read_value                   = word_next;
    read_value[`BIT_SDEV_STATUS] = sdev_status; // RULE_11
    read_value[`BIT_XFER_BUSY]   = pin_sync_reg[1];
    read_value[`BIT_DEV_ENABLED] = pin_sync_reg[0];
  end

  // reading word_next lets a read right after a write see it
  always_comb begin
    hrdata_next = 32'h0;
    if (rd_hit) begin
      hrdata_next = read_value;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_reg <= 32'h0;
    end else begin
      hrdata_reg <= hrdata_next;
    end
  end

  assign hrdata_o = hrdata_reg;

  // absent nonsec control leaves transfers non-secure
  assign hnonsec_o = HAS_NONSEC ? word_reg[`BIT_NONSEC] : 1'b1; // RULE_01

  assign hmaster_o = (!HAS_REQ_EMU || word_reg[`BIT_REQ_SELECT]) ?
                     OWN_REQ_ID : EMU_REQ_ID; // RULE_04 RULE_05

  always_comb begin
    if (ENHANCED_PROT) begin
      hprot_o = {word_reg[`BIT_PROT_ENH6], 1'b0,
                 word_reg[`BIT_PROT_ENH4:`BIT_PROT_LO]}; // RULE_10 RULE_08
    end else begin
      hprot_o = {word_reg[`BIT_PROT_HI], 1'b0, word_reg[`BIT_PROT_HI],
                 word_reg[`BIT_PROT_HI:`BIT_PROT_LO]}; // RULE_09 RULE_08
    end
  end

  assign xfer_hsize_o = word_reg[`BIT_SIZE_HI:`BIT_SIZE_LO]; // RULE_14
  assign address_increment_mode_o = word_reg[`BIT_INC_HI:`BIT_INC_LO];
  assign debug_software_access_enable_o = word_reg[`BIT_SW_ENABLE];
  assign stop_on_error_o        = word_reg[`BIT_STOP_ON_ERR];
  assign error_no_passthrough_o = word_reg[`BIT_ERR_NO_PASS];

  // checks
  sequence wr_data_phase;
    wr_pend_reg;
  endsequence

  sequence rd_addr_phase;
    rd_hit;
  endsequence

  nonsec_follow_a: assert property ( // RULE_01
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_data_phase ##0 (HAS_NONSEC == 1'b1) |=>
      hnonsec_o == $past(hwdata_i[`BIT_NONSEC]))
    else $error("nonsec attribute does not follow written bit");

  nonsec_fixed_a: assert property ( // RULE_02
    @(posedge mclk_i) disable iff (!rst_n_i)
    (HAS_NONSEC == 1'b0) |-> hnonsec_o)
    else $error("nonsec attribute changed without control bit");

  master_own_a: assert property ( // RULE_04
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_data_phase ##0 hwdata_i[`BIT_REQ_SELECT] |=>
      hmaster_o == OWN_REQ_ID)
    else $error("own requester identity not driven");

  master_emu_a: assert property ( // RULE_05
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_data_phase ##0 !hwdata_i[`BIT_REQ_SELECT] |=>
      hmaster_o == (HAS_REQ_EMU ? EMU_REQ_ID : OWN_REQ_ID))
    else $error("emulated requester identity wrong");

  select_rsvd_a: assert property ( // RULE_06
    @(posedge mclk_i) disable iff (!rst_n_i)
    rd_addr_phase ##0 (HAS_REQ_EMU == 1'b0) |=>
      !hrdata_o[`BIT_REQ_SELECT])
    else $error("select bit reads one without emulation");

  prot5_low_a: assert property ( // RULE_08
    @(posedge mclk_i) disable iff (!rst_n_i)
    !hprot_o[5])
    else $error("protection bit five driven high");

  prot_plain_a: assert property ( // RULE_09
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_data_phase ##0 (ENHANCED_PROT == 1'b0) |=>
      (hprot_o[6] == $past(hwdata_i[27])) &&
      (hprot_o[4] == $past(hwdata_i[27])) &&
      (hprot_o[3:0] == $past(hwdata_i[27:24])))
    else $error("plain protection mapping wrong");

  prot_enh_a: assert property ( // RULE_10
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_data_phase ##0 (ENHANCED_PROT == 1'b1) |=>
      hprot_o[4:0] == $past(hwdata_i[28:24]) &&
      hprot_o[6] == $past(hwdata_i[15]))
    else $error("enhanced protection mapping wrong");

  sdev_ro_a: assert property ( // RULE_11
    @(posedge mclk_i) disable iff (!rst_n_i)
    rd_addr_phase |=> hrdata_o[`BIT_SDEV_STATUS] ==
      (HAS_SECURE_DBG && (!SDEV_TRACKS || $past(pin_sync_reg[2]))))
    else $error("secure debug status read wrong");

  size_legal_a: assert property ( // RULE_14
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_data_phase ##0 size_ok |=>
      xfer_hsize_o == $past(hwdata_i[2:0]) ##1 xfer_hsize_o <= 3'h2)
    else $error("transfer size not taken or illegal");

  packed_opt_a: assert property ( // RULE_15
    @(posedge mclk_i) disable iff (!rst_n_i)
    (HAS_PACKED_INC == 1'b0) |-> address_increment_mode_o != 2'h2)
    else $error("packed increment without support");

  rsvd_zero_a: assert property ( // RULE_17
    @(posedge mclk_i) disable iff (!rst_n_i)
    rd_addr_phase |=> hrdata_o[22:18] == 5'h0 &&
      hrdata_o[11:8] == 4'h0 && !hrdata_o[3])
    else $error("reserved bits read nonzero");

  // reset values and refused writes
  reset_word_a: assert property ( // RULE_03
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> hnonsec_o && hmaster_o == OWN_REQ_ID &&
      hprot_o == {3'h0, `PROT_RESET} && xfer_hsize_o == `SIZE_RESET)
    else $error("sideband not at reset values after reset");

  sdev_store_a: assert property ( // RULE_11
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_data_phase |=> !word_reg[`BIT_SDEV_STATUS])
    else $error("secure debug status bit was stored");

  store_mask_a: assert property ( // RULE_17
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_data_phase |=> (word_reg & ~WMASK) == 32'h0)
    else $error("bit outside the writable fields was stored");

  nonsec_absent_a: assert property ( // RULE_02
    @(posedge mclk_i) disable iff (!rst_n_i)
    rd_addr_phase ##0 (HAS_NONSEC == 1'b0) |=> !hrdata_o[`BIT_NONSEC])
    else $error("absent nonsec control reads one");

  rsvd_plain_a: assert property ( // RULE_17
    @(posedge mclk_i) disable iff (!rst_n_i)
    rd_addr_phase ##0 (ENHANCED_PROT == 1'b0) |=>
      !hrdata_o[`BIT_PROT_ENH4] && hrdata_o[15:12] == 4'h0)
    else $error("plain layout reserved bits read nonzero");

  rsvd_enh_a: assert property ( // RULE_17
    @(posedge mclk_i) disable iff (!rst_n_i)
    rd_addr_phase ##0 (ENHANCED_PROT == 1'b1) |=> hrdata_o[14:12] == 3'h0)
    else $error("enhanced layout reserved bits read nonzero");

  size_keep_a: assert property ( // RULE_14
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_data_phase ##0 !size_ok |=> $stable(xfer_hsize_o))
    else $error("illegal size write changed the size field");

  inc_keep_a: assert property ( // RULE_15
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_data_phase ##0 !inc_ok |=> $stable(address_increment_mode_o))
    else $error("refused increment write changed the field");

  rd_idle_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !rd_hit |=> hrdata_o == 32'h0)
    else $error("read data stands beyond its data phase");

endmodule : ahb_access_port_control

// [logic/ahb_port_control_defines.svh]
// offsets, field positions, reset values for the port control word
//
// Behaviour
// RULE_01: nonsec control bit drives the nonsec attribute
// RULE_02: nonsec control present only if built in
// RULE_03: nonsec control resets to one
// RULE_04: select one drives own requester identity
// RULE_05: select zero drives emulated requester identity
// RULE_06: without emulation, select bit reads zero
// RULE_07: emulation support fixed at build time
// RULE_08: protection bit five always driven low
// RULE_09: plain layout protection bit mapping
// RULE_10: enhanced layout protection bit mapping
// RULE_11: secure debug status bit is read-only
// RULE_12: secure debug unsupported reads zero
// RULE_13: secure debug status may track authentication
// RULE_14: size field accepts word, half, byte
// RULE_15: packed increment supported only if built in
// RULE_16: no extra address space select bit
// RULE_17: reserved bits read zero, ignore writes
`ifndef AHB_PORT_CONTROL_DEFINES_SVH
`define AHB_PORT_CONTROL_DEFINES_SVH

`define CTRL_WORD_OFFSET   12'h000
`define BUS_ADDR_W         12

`define BIT_SW_ENABLE      31
`define BIT_NONSEC         30
`define BIT_REQ_SELECT     29
`define BIT_PROT_ENH4      28
`define BIT_PROT_HI        27
`define BIT_PROT_LO        24
`define BIT_SDEV_STATUS    23
`define BIT_STOP_ON_ERR    17
`define BIT_ERR_NO_PASS    16
`define BIT_PROT_ENH6      15
`define BIT_XFER_BUSY      7
`define BIT_DEV_ENABLED    6
`define BIT_INC_HI         5
`define BIT_INC_LO         4
`define BIT_SIZE_HI        2
`define BIT_SIZE_LO        0

`define SIZE_RESET         3'h2
`define PROT_RESET         4'h3
`define INC_RESET          2'h0

`endif

// [logic/ahb_port_control_pkg.sv]
// types for the access port control word
package ahb_port_control_pkg;

  typedef enum logic [2:0] {
    size_byte,
    size_half,
    size_word
  } xfer_size_e;

  typedef enum logic [1:0] {
    inc_off,
    inc_single,
    inc_packed,
    inc_illegal
  } addr_inc_e;

  typedef logic [31:0] word_t;

endpackage : ahb_port_control_pkg

// [tb/ahb_sideband_sink.sv]
// far-side model: a subordinate that captures the issued attributes
module ahb_sideband_sink (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // attributes from the port
  input  wire logic        hnonsec_i,
  input  wire logic [3:0]  hmaster_i,
  input  wire logic [6:0]  hprot_i,
  input  wire logic [2:0]  hsize_i,
  // last captured attributes
  output logic      [14:0] seen_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // only samples, never drives back: attributes are not negotiable
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seen_o <= 15'h0000;
    end else begin
      seen_o <= {hnonsec_i, hmaster_i, hprot_i, hsize_i};
    end
  end
endmodule : ahb_sideband_sink

// [tb/ahb_access_port_control_word_test.sv]
// testbench: plain layout beside a stripped enhanced layout
module ahb_access_port_control_word_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] own = 4'h1;
  localparam logic [3:0] emu = 4'h2;
  logic        mclk, rst_n, hready, hwrite, auth, busy_pin, en_pin;
  logic        hresp1, hnonsec1, hnonsec2;
  logic        hsel, hready2, hresp2, swen1, swen2, stop1, stop2;
  logic        errnp1, errnp2;
  logic [1:0]  htrans, inc1, inc2;
  logic [2:0]  hsize, hsize1, hsize2;
  logic [3:0]  hmaster1, hmaster2;
  logic [6:0]  hprot1, hprot2;
  logic [14:0] seen;
  logic [31:0] haddr, hwdata, hrdata1, hrdata2, rd1, rd2;
  int          errors, compares;

  ahb_access_port_control #(.OWN_REQ_ID(own), .EMU_REQ_ID(emu))
  i_ahb_access_port_control (.mclk_i(mclk), .rst_n_i(rst_n), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
    .hresp_o(hresp1), .hrdata_o(hrdata1), .secure_debug_auth_i(auth),
    .transfer_in_progress_i(busy_pin), .port_device_enabled_i(en_pin),
    .hnonsec_o(hnonsec1), .hmaster_o(hmaster1), .hprot_o(hprot1),
    .xfer_hsize_o(hsize1), .address_increment_mode_o(inc1),
    .debug_software_access_enable_o(swen1), .stop_on_error_o(stop1),
    .error_no_passthrough_o(errnp1));
  // second build: enhanced mapping, no nonsec, no emulation, no secure
  ahb_access_port_control #(.HAS_NONSEC(1'b0), .HAS_REQ_EMU(1'b0),
    .ENHANCED_PROT(1'b1), .HAS_SECURE_DBG(1'b0), .HAS_PACKED_INC(1'b0),
    .OWN_REQ_ID(own), .EMU_REQ_ID(emu))
  i_ahb_access_port_control_2 (.mclk_i(mclk), .rst_n_i(rst_n),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready2),
    .hresp_o(hresp2), .hrdata_o(hrdata2), .secure_debug_auth_i(auth),
    .transfer_in_progress_i(busy_pin), .port_device_enabled_i(en_pin),
    .hnonsec_o(hnonsec2), .hmaster_o(hmaster2), .hprot_o(hprot2),
    .xfer_hsize_o(hsize2), .address_increment_mode_o(inc2),
    .debug_software_access_enable_o(swen2), .stop_on_error_o(stop2),
    .error_no_passthrough_o(errnp2));
  ahb_sideband_sink i_ahb_sideband_sink (.mclk_i(mclk), .rst_n_i(rst_n),
    .hnonsec_i(hnonsec1), .hmaster_i(hmaster1), .hprot_i(hprot1),
    .hsize_i(hsize1), .seen_o(seen));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [31:0] pk(input logic n, input logic [3:0] m,
    input logic [6:0] p, input logic [2:0] s, input logic [1:0] i);
    return {15'h0000, n, m, p, s, i};
  endfunction : pk

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one single word transfer; read data taken at the data-phase edge
  task automatic bus(input logic wr, input logic [31:0] a,
    input logic [31:0] d);
    @(posedge mclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    rd1 = hrdata1;
    rd2 = hrdata2;
  endtask : bus

  task automatic side(input logic [31:0] e1, input logic [31:0] e2);
    @(negedge mclk);
    chk(pk(hnonsec1, hmaster1, hprot1, hsize1, inc1), e1);
    chk(pk(hnonsec2, hmaster2, hprot2, hsize2, inc2), e2);
    @(negedge mclk);
    chk({17'h00000, seen}, {17'h00000, e1[16:2]});
  endtask : side

  // enable, stop and pass-through flags of both builds
  task automatic flags(input logic [2:0] f);
    @(negedge mclk);
    chk({29'h0, swen1, stop1, errnp1}, {29'h0, f});
    chk({29'h0, swen2, stop2, errnp2}, {29'h0, f});
  endtask : flags

  task automatic t_reset;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    side(pk(1, own, 7'h03, 3'h2, 0), pk(1, own, 7'h03, 3'h2, 0));
    bus(0, 32'h0, 32'h0);
    chk(rd1, 32'h6300_0002);
    chk(rd2, 32'h0300_0002);
    chk({31'h0, hresp1}, 32'h0);
    chk({30'h0, hready2, hresp2}, 32'h2);
    flags(3'h0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_ones;
    bus(1, 32'h0, 32'hffff_ffff);
    side(pk(1, own, 7'h5f, 3'h2, 0), pk(1, own, 7'h5f, 3'h2, 0));
    flags(3'h7);
    bus(0, 32'h0, 32'h0);
    chk(rd1, 32'hef03_0002);
    chk(rd2, 32'h9f03_8002);
    $display("all ones test done");
  endtask : t_ones

  task automatic t_prot;
    logic [31:0] w[4] = '{32'h0800_0000, 32'h1000_0000, 32'h0000_8000,
                          32'h0700_0000};
    logic [6:0] p1[4] = '{7'h58, 7'h00, 7'h00, 7'h07};
    logic [6:0] p2[4] = '{7'h08, 7'h10, 7'h40, 7'h07};
    for (int k = 0; k < 4; k++) begin
      bus(1, 32'h0, w[k]);
      side(pk(0, emu, p1[k], 0, 0), pk(1, own, p2[k], 0, 0));
    end
    flags(3'h0);
    $display("prot map test done");
  endtask : t_prot

  task automatic t_size;
    bus(1, 32'h0, 32'h6000_0012);
    side(pk(1, own, 0, 3'h2, 1), pk(1, own, 0, 3'h2, 1));
    for (int s = 0; s < 3; s++) begin
      bus(1, 32'h0, 32'h6000_0020 | s);
      side(pk(1, own, 0, s, 2), pk(1, own, 0, s, 1));
    end
    bus(1, 32'h0, 32'h6000_0013);
    side(pk(1, own, 0, 3'h2, 1), pk(1, own, 0, 3'h2, 1));
    $display("size test done");
  endtask : t_size

  task automatic t_status;
    @(posedge mclk);
    auth <= 1'b1;
    busy_pin <= 1'b1;
    en_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    bus(0, 32'h0, 32'h0);
    chk(rd1, 32'h6080_00d2);
    chk(rd2, 32'h0000_00d2);
    auth <= 1'b0;
    busy_pin <= 1'b0;
    en_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    bus(0, 32'h0, 32'h0);
    chk(rd1, 32'h6000_0012);
    $display("status test done");
  endtask : t_status

  task automatic t_unmapped;
    bus(1, 32'h4, 32'h0);
    bus(0, 32'h4, 32'h0);
    chk(rd1, 32'h0);
    // a deselected write must leave the word alone
    hsel <= 1'b0;
    bus(1, 32'h0, 32'h0);
    hsel <= 1'b1;
    bus(0, 32'h0, 32'h0);
    chk(rd1, 32'h6000_0012);
    chk(rd2, 32'h0000_0012);
    $display("unmapped test done");
  endtask : t_unmapped

  task automatic summarize;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  initial begin
    errors = 0;
    compares = 0;
    rst_n = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsel = 1'b1;
    hsize = 3'h2;
    hwdata = 32'h0;
    auth = 1'b0;
    busy_pin = 1'b0;
    en_pin = 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_ones();
    t_prot();
    t_size();
    t_status();
    t_unmapped();
    t_reset();
    summarize();
  end

  // whole run is about a hundred cycles
  initial begin
    #20000;
    errors++;
    summarize();
  end
endmodule : ahb_access_port_control_word_test
